// ---- rtl/wrf_defines.svh ----
`ifndef WRF_DEFINES_SVH
`define WRF_DEFINES_SVH

`define SLICE_A_ADDR   8'hD6
`define SLICE_B_ADDR   8'hD7
`define SP_HIGH_ADDR   8'hD8
`define SP_LOW_ADDR    8'hD9

`define SLICE_A_RESET  8'hC0
`define SLICE_B_RESET  8'hC8
`define SP_RESET       16'h0000
`define RESULT_RESET   24'h000000

`define WORK_PREFIX    4'hC
`define UPPER_AREA     2'h3
`define SET2_TAG       3'h4
`define MEM_DEPTH      320
`define IDX_W          9

`define SRP_BOTH       2'h0
`define SRP_A_ONLY     2'h1
`define SRP_B_ONLY     2'h2
`define SRP_B_OFFSET   8'h08

`endif

// ---- rtl/wrf_pkg.sv ----
`default_nettype none
package wrf_pkg;
`include "wrf_defines.svh"

   typedef enum logic [3:0] {
      CMD_READ        = 4'h0,
      CMD_WRITE       = 4'h1,
      CMD_READ_PAIR   = 4'h2,
      CMD_WRITE_PAIR  = 4'h3,
      CMD_PUSH        = 4'h4,
      CMD_POP         = 4'h5,
      CMD_CALL        = 4'h6,
      CMD_RET         = 4'h7,
      CMD_INT_ENTRY   = 4'h8,
      CMD_INT_RETURN  = 4'h9,
      CMD_UPUSH_INC   = 4'hA,
      CMD_UPUSH_DEC   = 4'hB,
      CMD_UPOP_INC    = 4'hC,
      CMD_UPOP_DEC    = 4'hD,
      CMD_SET_SLICES  = 4'hE
   } cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'h1,
      ST_ISSUE   = 4'h2,
      ST_CAPTURE = 4'h4,
      ST_DONE    = 4'h8
   } state_t;

   typedef enum logic [1:0] {
      SRC_DIR  = 2'h0,
      SRC_PUSH = 2'h1,
      SRC_POP  = 2'h2,
      SRC_IND  = 2'h3
   } src_t;

   typedef enum logic [2:0] {
      CAP_NONE  = 3'h0,
      CAP_TMP   = 3'h1,
      CAP_LO    = 3'h2,
      CAP_HI    = 3'h3,
      CAP_FLAGS = 3'h4
   } cap_t;

   // Indirect accesses to the upper area land in the second set.
   function automatic logic [`IDX_W-1:0] ind_index(input logic [7:0] a);
      if (a[7:6] == `UPPER_AREA) begin
         ind_index = {`SET2_TAG, a[5:0]};
      end else begin
         ind_index = {1'b0, a};
      end
   endfunction

   function automatic logic is_special(input logic [7:0] a);
      is_special = (a == `SLICE_A_ADDR) || (a == `SLICE_B_ADDR) ||
                   (a == `SP_HIGH_ADDR) || (a == `SP_LOW_ADDR);
   endfunction

endpackage

`default_nettype wire

// ---- rtl/regfile_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wrf_defines.svh"

module regfile_mem (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             en,
   input  wire logic             we,
   input  wire logic [`IDX_W-1:0] idx,
   input  wire logic [7:0]       wdata,
   output logic      [7:0]       rdata
);

   logic [7:0] mem_array [0:`MEM_DEPTH-1];

   always_ff @(posedge clk) begin
      if (en && we) begin
         mem_array[idx] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= 8'h00;
      end else if (en && !we) begin
         rdata <= mem_array[idx];
      end
   end

endmodule // regfile_mem

`default_nettype wire

// ---- rtl/wreg_addr.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wrf_defines.svh"

module wreg_addr (
   input  wire logic       short_form,
   input  wire logic [7:0] operand,
   input  wire logic [7:0] slice_a,
   input  wire logic [7:0] slice_b,
   output logic      [7:0] addr
);

   logic       working;
   logic [7:0] chosen;

   always_comb begin
      working = short_form || (operand[7:4] == `WORK_PREFIX);
      chosen  = operand[3] ? slice_b : slice_a;
      if (working) begin
         addr = {chosen[7:3], operand[2:0]};
      end else begin
         addr = operand;
      end
   end

endmodule // wreg_addr

`default_nettype wire

// ---- rtl/working_register_and_stack_addr.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wrf_defines.svh"

// Operation
// - Direct operands reach every register location outside the second set.
// - A register pair starts at an even address, second byte odd.
// - Pair high byte sits at the even address, low byte at plus one.
// - After reset the slice pointers select C0H-C7H and C8H-CFH.
// - Short operand top bit picks slice pointer A or B.
// - Top five pointer bits form address bits seven to three.
// - Low three operand bits form address bits two to zero.
// - Long operand with upper nibble 1100B resolves like a short one.
// - In that long form, operand bit three picks the pointer.
// - Call saves the program counter on the stack; return restores it.
// - Interrupt entry pushes counter and flags; interrupt return pops both.
// - Stack pointer decrements before each push, increments after each pop.
// - The system stack lives in the internal register file.
// - Stack pointer high byte at D8H, low byte at D9H.
// - The stack pointer has no defined value after reset; reset here clears it to 0000H.
// - Low byte carry or borrow propagates into the high byte.
// - High stack byte acts as an ordinary data register.
// - Four user push and pop operations serve software stacks.
// - Slice pointers live at D6H and D7H.
// - The second set is reached only by indirect operands.
module working_register_and_stack_addr (
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic          req_valid,
   input  wire wrf_pkg::cmd_t req_cmd,
   input  wire logic          req_short,
   input  wire logic [7:0]    req_operand,
   input  wire logic [15:0]   req_wdata,
   input  wire logic [7:0]    req_flags,
   output logic               req_ready,
   output logic               ack,
   output logic [15:0]        rdata,
   output logic [7:0]         flags_rdata,
   output logic [7:0]         slice_pointer_a,
   output logic [7:0]         slice_pointer_b,
   output logic [15:0]        stack_pointer
);
   import wrf_pkg::*;

   state_t       state_reg,  state_next;
   cmd_t         cmd_reg,    cmd_next;
   logic [1:0]   step_reg,   step_next;
   logic [7:0]   addr_reg,   addr_next;
   logic [15:0]  wdata_reg,  wdata_next;
   logic [7:0]   flags_reg,  flags_next;
   logic [7:0]   tmp_reg,    tmp_next;
   logic [23:0]  result_reg, result_next;
   logic [7:0]   slice_a_reg, slice_a_next;
   logic [7:0]   slice_b_reg, slice_b_next;
   logic [15:0]  sp_reg,     sp_next;
   logic         last_reg,   last_next;
   logic         hit_reg,    hit_next;
   logic [7:0]   spec_reg,   spec_next;
   cap_t         cap_reg,    cap_next;
   logic         ack_reg,    ack_next;
   logic         ready_reg,  ready_next;
   logic         post_reset_reg;

   logic [7:0]       res_addr;
   logic             mem_en;
   logic             mem_we;
   logic [`IDX_W-1:0] mem_idx;
   logic [7:0]       mem_rdata;
   logic             accept;

   src_t         s_src;
   cap_t         s_cap;
   logic         s_write;
   logic         s_last;
   logic         s_hit;
   logic [7:0]   s_addr8;
   logic [7:0]   s_wd;
   logic [7:0]   s_spec;
   logic [`IDX_W-1:0] s_idx;
   logic [7:0]   pair0;
   logic [7:0]   pair1;
   logic [7:0]   up_ptr;
   logic [7:0]   cap_data;
   logic [15:0]  sp_dn;
   logic [15:0]  sp_up;

   wreg_addr u_addr (
      .short_form (req_short),
      .operand    (req_operand),
      .slice_a    (slice_a_reg),
      .slice_b    (slice_b_reg),
      .addr       (res_addr)
   );

   regfile_mem u_mem (
      .clk    (clk),
      .resetn (resetn),
      .en     (mem_en),
      .we     (mem_we),
      .idx    (mem_idx),
      .wdata  (s_wd),
      .rdata  (mem_rdata)
   );

   assign accept = (state_reg == ST_IDLE) && req_valid;

   // Step decode: every command but CMD_SET_SLICES is a short list of byte steps.
   always_comb begin
      pair0   = {addr_reg[7:1], 1'b0};
      pair1   = {addr_reg[7:1], 1'b1};
      sp_dn   = sp_reg - 16'h0001;
      sp_up   = sp_reg + 16'h0001;
      up_ptr  = ((cmd_reg == CMD_UPUSH_INC) || (cmd_reg == CMD_UPOP_INC)) ?
                tmp_reg + 8'h01 : tmp_reg - 8'h01;
      s_src   = SRC_DIR;
      s_cap   = CAP_NONE;
      s_write = 1'b0;
      s_last  = 1'b1;
      s_addr8 = addr_reg;
      s_wd    = wdata_reg[7:0];
      unique case (cmd_reg)
         CMD_READ: begin
            s_cap = CAP_LO;
         end
         CMD_WRITE: begin
            s_write = 1'b1;
         end
         CMD_READ_PAIR: begin
            s_addr8 = (step_reg == 2'h0) ? pair0 : pair1;
            s_cap   = (step_reg == 2'h0) ? CAP_HI : CAP_LO;
            s_last  = (step_reg != 2'h0);
         end
         CMD_WRITE_PAIR: begin
            s_write = 1'b1;
            s_addr8 = (step_reg == 2'h0) ? pair0 : pair1;
            s_wd    = (step_reg == 2'h0) ? wdata_reg[15:8] : wdata_reg[7:0];
            s_last  = (step_reg != 2'h0);
         end
         CMD_PUSH: begin
            s_src   = SRC_PUSH;
            s_write = 1'b1;
         end
         CMD_POP: begin
            s_src = SRC_POP;
            s_cap = CAP_LO;
         end
         CMD_CALL: begin
            s_src   = SRC_PUSH;
            s_write = 1'b1;
            s_wd    = (step_reg == 2'h0) ? wdata_reg[7:0] : wdata_reg[15:8];
            s_last  = (step_reg != 2'h0);
         end
         CMD_RET: begin
            s_src  = SRC_POP;
            s_cap  = (step_reg == 2'h0) ? CAP_HI : CAP_LO;
            s_last = (step_reg != 2'h0);
         end
         CMD_INT_ENTRY: begin
            s_src   = SRC_PUSH;
            s_write = 1'b1;
            s_wd    = (step_reg == 2'h0) ? wdata_reg[7:0] :
                      (step_reg == 2'h1) ? wdata_reg[15:8] : flags_reg;
            s_last  = (step_reg == 2'h2);
         end
         CMD_INT_RETURN: begin
            s_src  = SRC_POP;
            s_cap  = (step_reg == 2'h0) ? CAP_FLAGS :
                     (step_reg == 2'h1) ? CAP_HI : CAP_LO;
            s_last = (step_reg == 2'h2);
         end
         CMD_UPUSH_INC, CMD_UPUSH_DEC, CMD_UPOP_INC, CMD_UPOP_DEC: begin
            s_last = (step_reg == 2'h2);
            if (step_reg == 2'h0) begin
               s_cap = CAP_TMP;
            end else if (step_reg == 2'h2) begin
               s_write = 1'b1;
               s_wd    = up_ptr;
            end else if ((cmd_reg == CMD_UPUSH_INC) ||
                         (cmd_reg == CMD_UPUSH_DEC)) begin
               s_src   = SRC_IND;
               s_write = 1'b1;
               s_addr8 = up_ptr;
            end else begin
               s_src   = SRC_IND;
               s_addr8 = tmp_reg;
               s_cap   = CAP_LO;
            end
         end
         default: begin
            s_cap = CAP_NONE;
         end
      endcase
      unique case (s_src)
         SRC_DIR:  s_idx = {1'b0, s_addr8};
         SRC_PUSH: s_idx = ind_index(sp_dn[7:0]);
         SRC_POP:  s_idx = ind_index(sp_reg[7:0]);
         SRC_IND:  s_idx = ind_index(s_addr8);
      endcase
      s_hit = (s_src == SRC_DIR) && is_special(s_addr8);
      unique case (s_addr8)
         `SLICE_A_ADDR: s_spec = slice_a_reg;
         `SLICE_B_ADDR: s_spec = slice_b_reg;
         `SP_HIGH_ADDR: s_spec = sp_reg[15:8];
         default:       s_spec = sp_reg[7:0];
      endcase
   end

   // Sequencer: at most one memory access per step (none for direct accesses to D6H-D9H), two cycles per step.
   always_comb begin
      state_next   = state_reg;
      cmd_next     = cmd_reg;
      step_next    = step_reg;
      addr_next    = addr_reg;
      wdata_next   = wdata_reg;
      flags_next   = flags_reg;
      tmp_next     = tmp_reg;
      result_next  = result_reg;
      slice_a_next = slice_a_reg;
      slice_b_next = slice_b_reg;
      sp_next      = sp_reg;
      last_next    = last_reg;
      hit_next     = hit_reg;
      spec_next    = spec_reg;
      cap_next     = cap_reg;
      mem_en       = 1'b0;
      mem_we       = 1'b0;
      mem_idx      = s_idx;
      cap_data     = hit_reg ? spec_reg : mem_rdata;
      unique case (state_reg)
         ST_IDLE: begin
            if (req_valid) begin
               cmd_next   = req_cmd;
               addr_next  = res_addr;
               wdata_next = req_wdata;
               flags_next = req_flags;
               step_next  = 2'h0;
               state_next = ST_ISSUE;
               if (req_cmd == CMD_SET_SLICES) begin
                  state_next = ST_DONE;
                  if (req_operand[1:0] == `SRP_BOTH) begin
                     slice_a_next = {req_wdata[7:4], 4'h0};
                     slice_b_next = {req_wdata[7:4], 4'h0} | `SRP_B_OFFSET;
                  end else if (req_operand[1:0] == `SRP_A_ONLY) begin
                     slice_a_next = req_wdata[7:0];
                  end else if (req_operand[1:0] == `SRP_B_ONLY) begin
                     slice_b_next = req_wdata[7:0];
                  end
               end
            end
         end
         ST_ISSUE: begin
            mem_en     = !s_hit;
            mem_we     = s_write;
            last_next  = s_last;
            hit_next   = s_hit;
            spec_next  = s_spec;
            cap_next   = s_cap;
            state_next = ST_CAPTURE;
            if (s_src == SRC_PUSH) begin
               sp_next = sp_dn;
            end else if (s_src == SRC_POP) begin
               sp_next = sp_up;
            end
            if (s_hit && s_write) begin
               unique case (s_addr8)
                  `SLICE_A_ADDR: slice_a_next = s_wd;
                  `SLICE_B_ADDR: slice_b_next = s_wd;
                  `SP_HIGH_ADDR: sp_next      = {s_wd, sp_reg[7:0]};
                  default:       sp_next      = {sp_reg[15:8], s_wd};
               endcase
            end
         end
         ST_CAPTURE: begin
            unique case (cap_reg)
               CAP_TMP:   tmp_next            = cap_data;
               CAP_LO:    result_next[7:0]    = cap_data;
               CAP_HI:    result_next[15:8]   = cap_data;
               CAP_FLAGS: result_next[23:16]  = cap_data;
               default:   tmp_next            = tmp_reg;
            endcase
            if (last_reg) begin
               state_next = ST_DONE;
            end else begin
               step_next  = step_reg + 2'h1;
               state_next = ST_ISSUE;
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;
         end
      endcase
      ack_next   = (state_next == ST_DONE);
      ready_next = (state_next == ST_IDLE);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg      <= ST_IDLE;
         cmd_reg        <= CMD_READ;
         step_reg       <= 2'h0;
         addr_reg       <= 8'h00;
         wdata_reg      <= 16'h0000;
         flags_reg      <= 8'h00;
         tmp_reg        <= 8'h00;
         result_reg     <= `RESULT_RESET;
         slice_a_reg    <= `SLICE_A_RESET;
         slice_b_reg    <= `SLICE_B_RESET;
         sp_reg         <= `SP_RESET;
         last_reg       <= 1'b0;
         hit_reg        <= 1'b0;
         spec_reg       <= 8'h00;
         cap_reg        <= CAP_NONE;
         ack_reg        <= 1'b0;
         ready_reg      <= 1'b1;
         post_reset_reg <= 1'b1;
      end else begin
         state_reg      <= state_next;
         cmd_reg        <= cmd_next;
         step_reg       <= step_next;
         addr_reg       <= addr_next;
         wdata_reg      <= wdata_next;
         flags_reg      <= flags_next;
         tmp_reg        <= tmp_next;
         result_reg     <= result_next;
         slice_a_reg    <= slice_a_next;
         slice_b_reg    <= slice_b_next;
         sp_reg         <= sp_next;
         last_reg       <= last_next;
         hit_reg        <= hit_next;
         spec_reg       <= spec_next;
         cap_reg        <= cap_next;
         ack_reg        <= ack_next;
         ready_reg      <= ready_next;
         post_reset_reg <= 1'b0;
      end
   end

   assign req_ready       = ready_reg;
   assign ack             = ack_reg;
   assign rdata           = result_reg[15:0];
   assign flags_rdata     = result_reg[23:16];
   assign slice_pointer_a = slice_a_reg;
   assign slice_pointer_b = slice_b_reg;
   assign stack_pointer   = sp_reg;

   property p_slice_reset;
      @(posedge clk) disable iff (!resetn)
      post_reset_reg |->
         (slice_a_reg == `SLICE_A_RESET) && (slice_b_reg == `SLICE_B_RESET);
   endproperty
   a_slice_reset: assert property (p_slice_reset)
      else $error("Slice pointers not at common area after reset.");

   property p_short_form;
      @(posedge clk) disable iff (!resetn)
      accept && req_short && !req_operand[3] |=>
         (addr_reg[7:3] == $past(slice_a_reg[7:3])) &&
         (addr_reg[2:0] == $past(req_operand[2:0]));
   endproperty
   a_short_form: assert property (p_short_form)
      else $error("Short operand address formed wrongly.");

   property p_long_form;
      @(posedge clk) disable iff (!resetn)
      accept && !req_short && (req_operand[7:3] == 5'h19) |=>
         (addr_reg == {$past(slice_b_reg[7:3]), $past(req_operand[2:0])});
   endproperty
   a_long_form: assert property (p_long_form)
      else $error("Long working operand did not use slice pointer B.");

   property p_push_dec;
      @(posedge clk) disable iff (!resetn)
      (state_reg == ST_ISSUE) && (s_src == SRC_PUSH) |=>
         (sp_reg == $past(sp_reg) - 16'h0001);
   endproperty
   a_push_dec: assert property (p_push_dec)
      else $error("Push did not decrement the stack pointer.");

   property p_borrow;
      @(posedge clk) disable iff (!resetn)
      (state_reg == ST_ISSUE) && (s_src == SRC_PUSH) &&
      (sp_reg[7:0] == 8'h00) |=>
         (sp_reg[15:8] == $past(sp_reg[15:8]) - 8'h01);
   endproperty
   a_borrow: assert property (p_borrow)
      else $error("Borrow did not reach the high stack byte.");

   property p_pair_even;
      @(posedge clk) disable iff (!resetn)
      (state_reg == ST_ISSUE) && !s_hit && (step_reg == 2'h0) &&
      ((cmd_reg == CMD_READ_PAIR) || (cmd_reg == CMD_WRITE_PAIR)) |->
         !mem_idx[0] ##2 mem_idx[0];
   endproperty
   a_pair_even: assert property (p_pair_even)
      else $error("Pair bytes not at even then odd address.");

   property p_pair_msb;
      @(posedge clk) disable iff (!resetn)
      (state_reg == ST_ISSUE) && (cmd_reg == CMD_WRITE_PAIR) &&
      (step_reg == 2'h0) |-> (s_wd == wdata_reg[15:8]);
   endproperty
   a_pair_msb: assert property (p_pair_msb)
      else $error("Pair high byte not written first at even address.");

   property p_call;
      @(posedge clk) disable iff (!resetn)
      accept && (req_cmd == CMD_CALL) |->
         ##4 (sp_reg == $past(sp_reg, 4) - 16'h0002) ##1 ack_reg;
   endproperty
   a_call: assert property (p_call)
      else $error("Call did not push two bytes and finish in time.");

   property p_int_entry;
      @(posedge clk) disable iff (!resetn)
      accept && (req_cmd == CMD_INT_ENTRY) |->
         ##6 (sp_reg == $past(sp_reg, 6) - 16'h0003) ##1 ack_reg;
   endproperty
   a_int_entry: assert property (p_int_entry)
      else $error("Interrupt entry did not push three bytes.");

   property p_set2;
      @(posedge clk) disable iff (!resetn)
      (state_reg == ST_ISSUE) && (s_src == SRC_POP) |->
         (mem_idx[8] == (sp_reg[7:6] == `UPPER_AREA));
   endproperty
   a_set2: assert property (p_set2)
      else $error("Stack access in the upper area missed set two.");

endmodule // working_register_and_stack_addr

`default_nettype wire

// ---- testbench/cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module cpu_model
   import wrf_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           req_ready,
   input  wire logic           ack,
   output var  logic           req_valid,
   output var  wrf_pkg::cmd_t  req_cmd,
   output var  logic           req_short,
   output var  logic [7:0]     req_operand,
   output var  logic [15:0]    req_wdata,
   output var  logic [7:0]     req_flags
);
   initial begin
      req_valid = 1'b0;
      req_cmd = CMD_READ;
      req_short = 1'b0;
      req_operand = 8'h00;
      req_wdata = 16'h0000;
      req_flags = 8'h00;
   end

   // Caller picks operands.
   // Released operand, data and flag lines are inverted so a stale value is never read as fresh.
   task automatic issue(input cmd_t c, input logic s, input logic [7:0] o,
                        input logic [15:0] w, input logic [7:0] f,
                        output logic ok);
      int n;
      ok = 1'b0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_short <= s;
      req_operand <= o;
      req_wdata <= w;
      req_flags <= f;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge clk);
         ok = (req_ready === 1'b1);
      end
      req_valid <= 1'b0;
      req_operand <= ~o;
      req_wdata <= ~w;
      req_flags <= ~f;
      if (ok) begin
         ok = 1'b0;
         for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            ok = (ack === 1'b1);
         end
      end
   endtask
endmodule // cpu_model

`default_nettype wire

// ---- testbench/working_register_and_stack_addr_bench.sv ----
`timescale 1ns/10ps
`default_nettype none

module working_register_and_stack_addr_bench;
   import wrf_pkg::*;
   typedef struct packed {
      logic [1:0]  kind;
      logic [15:0] val;
      logic [7:0]  fv;
   } note_t;
   logic          clk;
   logic          resetn;
   logic          req_valid;
   cmd_t          req_cmd;
   logic          req_short;
   logic [7:0]    req_operand;
   logic [15:0]   req_wdata;
   logic [7:0]    req_flags;
   logic          req_ready;
   logic          ack;
   logic [15:0]   rdata;
   logic [7:0]    flags_rdata;
   logic [7:0]    sa;
   logic [7:0]    sb;
   logic [15:0]   sp;
   note_t         notes[$];
   note_t         nt;
   int            n_fail = 0;
   int            samples_checked = 0;
   logic [15:0]   rng = 16'h0012;

   cpu_model cpu_u (.clk(clk), .req_ready(req_ready), .ack(ack),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_short(req_short),
      .req_operand(req_operand), .req_wdata(req_wdata),
      .req_flags(req_flags));
   working_register_and_stack_addr dut_u (.clk(clk), .resetn(resetn),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_short(req_short),
      .req_operand(req_operand), .req_wdata(req_wdata),
      .req_flags(req_flags), .req_ready(req_ready), .ack(ack),
      .rdata(rdata), .flags_rdata(flags_rdata), .slice_pointer_a(sa),
      .slice_pointer_b(sb), .stack_pointer(sp));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic cmp(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_data(input logic [15:0] e, input logic [15:0] g);
      cmp("rdata", e, g);
   endtask

   task automatic cmp_flags(input logic [7:0] e);
      cmp("flags_rdata", {8'h00, e}, {8'h00, flags_rdata});
   endtask

   task automatic cmp_ptr(input logic [15:0] e);
      cmp("slice pointers", e, {sa, sb});
   endtask

   task automatic cmp_sp(input logic [15:0] e);
      cmp("stack_pointer", e, sp);
   endtask

   function automatic logic [15:0] xorshift(input logic [15:0] v);
      logic [15:0] x;
      x = v ^ (v << 7);
      x = x ^ (x >> 9);
      xorshift = x ^ (x << 8);
   endfunction

   task automatic end_sim;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Each acknowledge retires the oldest note. The falling edge is used so
   // the last check of a run cannot race the verdict at the rising edge.
   always @(negedge clk) begin
      if (ack === 1'b1) begin
         if (notes.size() == 0) begin
            cmp("ack", 16'h0000, 16'h0001);
         end else begin
            nt = notes.pop_front();
            if (nt.kind == 2'h1) begin
               cmp_data(nt.val, {8'h00, rdata[7:0]});
            end
            if (nt.kind >= 2'h2) begin
               cmp_data(nt.val, rdata);
            end
            if (nt.kind == 2'h3) begin
               cmp_flags(nt.fv);
            end
         end
      end
   end

   task automatic op(input cmd_t c, input logic s, input logic [7:0] o,
                     input logic [15:0] w, input logic [1:0] k,
                     input logic [15:0] e, input logic [7:0] f = 8'h00);
      logic ok;
      notes.push_back('{k, e, f});
      cpu_u.issue(c, s, o, w, f, ok);
      if (!ok) begin
         n_fail++;
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      op(CMD_WRITE, 1'b0, a, {8'h00, d}, 2'h0, 16'h0000);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] d);
      op(CMD_READ, 1'b0, a, 16'h0000, 2'h1, {8'h00, d});
   endtask

   initial begin
      resetn = 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      cmp_ptr(16'hC0C8);
      op(CMD_SET_SLICES, 1'b0, 8'h00, 16'h0070, 2'h0, 16'h0000);
      cmp_ptr(16'h7078);
      op(CMD_WRITE, 1'b1, 8'h06, 16'h00A6, 2'h0, 16'h0000);
      rd(8'h76, 8'hA6);
      op(CMD_WRITE, 1'b0, 8'hCB, 16'h00B3, 2'h0, 16'h0000);
      rd(8'h7B, 8'hB3);
      op(CMD_SET_SLICES, 1'b0, 8'h01, 16'h0085, 2'h0, 16'h0000);
      op(CMD_WRITE, 1'b1, 8'h02, 16'h0042, 2'h0, 16'h0000);
      rd(8'h82, 8'h42);
      repeat (6) begin
         rng = xorshift(rng);
         op(CMD_WRITE, 1'b1, {4'h0, rng[3:0]}, rng, 2'h0, 16'h0000);
         rd({(rng[3] ? 5'h0F : 5'h10), rng[2:0]}, rng[7:0]);
      end
      op(CMD_WRITE_PAIR, 1'b0, 8'h41, 16'h1234, 2'h0, 16'h0000);
      rd(8'h40, 8'h12);
      rd(8'h41, 8'h34);
      op(CMD_READ_PAIR, 1'b0, 8'h40, 16'h0000, 2'h2, 16'h1234);
      wr(8'hD8, 8'h05);
      wr(8'hD9, 8'h00);
      cmp_sp(16'h0500);
      op(CMD_PUSH, 1'b0, 8'h00, 16'h00AB, 2'h0, 16'h0000);
      cmp_sp(16'h04FF);
      op(CMD_POP, 1'b0, 8'h00, 16'h0000, 2'h1, 16'h00AB);
      cmp_sp(16'h0500);
      wr(8'hD9, 8'hFF);
      op(CMD_CALL, 1'b0, 8'h00, 16'h1234, 2'h0, 16'h0000);
      cmp_sp(16'h05FD);
      op(CMD_RET, 1'b0, 8'h00, 16'h0000, 2'h2, 16'h1234);
      op(CMD_INT_ENTRY, 1'b0, 8'h00, 16'h5678, 2'h0, 16'h0000, 8'h9A);
      cmp_sp(16'h05FC);
      op(CMD_INT_RETURN, 1'b0, 8'h00, 16'h0000, 2'h3,
         16'h5678, 8'h9A);
      wr(8'hD8, 8'h3C);
      rd(8'hD8, 8'h3C);
      wr(8'hD9, 8'h20);
      op(CMD_PUSH, 1'b0, 8'h00, 16'h005A, 2'h0, 16'h0000);
      rd(8'h1F, 8'h5A);
      wr(8'hEF, 8'h11);
      wr(8'hD9, 8'hF0);
      op(CMD_PUSH, 1'b0, 8'h00, 16'h0099, 2'h0, 16'h0000);
      rd(8'hEF, 8'h11);
      wr(8'h30, 8'h50);
      op(CMD_UPUSH_INC, 1'b0, 8'h30, 16'h0077, 2'h0, 16'h0000);
      rd(8'h51, 8'h77);
      rd(8'h30, 8'h51);
      op(CMD_UPOP_DEC, 1'b0, 8'h30, 16'h0000, 2'h1, 16'h0077);
      op(CMD_UPUSH_DEC, 1'b0, 8'h30, 16'h0066, 2'h0, 16'h0000);
      rd(8'h4F, 8'h66);
      op(CMD_UPOP_INC, 1'b0, 8'h30, 16'h0000, 2'h1, 16'h0066);
      rd(8'h30, 8'h50);
      op(CMD_SET_SLICES, 1'b0, 8'h02, 16'h0048, 2'h0, 16'h0000);
      cmp_ptr(16'h8548);
      op(CMD_SET_SLICES, 1'b0, 8'h03, 16'h0011, 2'h0, 16'h0000);
      cmp_ptr(16'h8548);
      wr(8'hD6, 8'h30);
      rd(8'hD7, 8'h48);
      cmp_ptr(16'h3048);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      cmp_ptr(16'hC0C8);
      end_sim();
   end
endmodule // working_register_and_stack_addr_bench

`default_nettype wire
